// ===== design/uaist_rx_queue.v
// Receive byte queue held in flip-flops.
// Assumes the parent judges overrun; a push into a full queue is dropped unless a pop frees a slot.
`timescale 1ns/1ns
module uaist_rx_queue #(
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Write side
  input wire push,
  input wire [7:0] push_data,
  // Read side
  input wire pop,
  input wire flush,
  output wire [7:0] head_data,
  output wire empty,
  output wire full
);

  reg [7:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  integer i;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  assign empty = (count_r == {(AW+1){1'b0}});
  assign full = (count_r == DEPTH[AW:0]);
  assign head_data = mem_r[rptr_r];

  // A pop in the same cycle frees the slot, so the byte is kept
  wire do_push = push && (!full || (pop && !empty));
  wire do_pop = pop && !empty;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem_r[i] <= 8'h00;
    end
    else if (flush)
    begin
      // Discard everything held
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
      begin
        mem_r[wptr_r] <= push_data;
        wptr_r <= ptr_inc(wptr_r);
      end
      if (do_pop)
        rptr_r <= ptr_inc(rptr_r);
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule // uaist_rx_queue

// ===== design/uaist_top.v
// Receive/transmit status, interrupt sources and address detect behind APB.
// Assumes the receiver core delivers one strobe per received character with its
// error and ninth-bit qualifiers; transmit status levels/pulses come from the
// transmit core.
`timescale 1ns/1ns
`include "uaist_regs.vh"
module uaist_top #(
  parameter ADDR_DETECT = 1,
  parameter HALF_DUPLEX = 0,
  parameter RX_INT_PRESENT = 1,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Receiver core
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_char_parity_bad,
  input wire rx_char_stop_low,
  input wire rx_char_ninth,
  input wire rx_break_detect,
  input wire rx_ring_overflow,
  // Transmitter core
  input wire tx_byte_done,
  input wire tx_queue_empty,
  input wire tx_queue_full,
  // Controls and interrupts
  output wire half_duplex_direction,
  output wire [2:0] rx_addr_mode_field,
  output wire rx_irq,
  output wire tx_irq
);

  // ***************************************************
  // Bus decode
  // ***************************************************
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  assign pready = 1'b1;

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire mapped = hit(paddr, `UAIST_RX_STATUS_OFS) || hit(paddr, `UAIST_RX_DATA_OFS) ||
    hit(paddr, `UAIST_RX_MASK_OFS) || hit(paddr, `UAIST_TX_STATUS_OFS) ||
    hit(paddr, `UAIST_TX_MASK_OFS) || hit(paddr, `UAIST_CTRL_OFS) ||
    hit(paddr, `UAIST_ADDR1_OFS) || hit(paddr, `UAIST_ADDR2_OFS) || hit(paddr, `UAIST_CMD_OFS);
  assign pslverr = acc && !mapped;

  wire rd_rxs = rd && hit(paddr, `UAIST_RX_STATUS_OFS);
  wire rd_rxd = rd && hit(paddr, `UAIST_RX_DATA_OFS);
  wire rd_txs = rd && hit(paddr, `UAIST_TX_STATUS_OFS);
  wire rx_clear = wr && hit(paddr, `UAIST_CMD_OFS) && pwdata[`UAIST_CMD_RXCLR];

  // ***************************************************
  // Control registers
  // ***************************************************
  reg [7:0] ctrl_r;
  reg [7:0] rx_mask_r;
  reg [3:0] tx_mask_r;
  reg [7:0] addr1_r;
  reg [7:0] addr2_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `UAIST_CTRL_RST;
      rx_mask_r <= `UAIST_MASK_RST;
      tx_mask_r <= 4'h0;
      addr1_r <= `UAIST_ADDR_RST;
      addr2_r <= `UAIST_ADDR_RST;
    end
    else if (wr)
    begin
      if (hit(paddr, `UAIST_CTRL_OFS))
        ctrl_r <= pwdata[7:0];
      if (hit(paddr, `UAIST_RX_MASK_OFS))
        rx_mask_r <= pwdata[7:0];
      if (hit(paddr, `UAIST_TX_MASK_OFS))
        tx_mask_r <= pwdata[3:0];
      if (hit(paddr, `UAIST_ADDR1_OFS))
        addr1_r <= pwdata[7:0];
      if (hit(paddr, `UAIST_ADDR2_OFS))
        addr2_r <= pwdata[7:0];
    end
  end

  assign half_duplex_direction = ctrl_r[`UAIST_CTL_DIR];
  assign rx_addr_mode_field = ctrl_r[`UAIST_CTL_AM_HI:`UAIST_CTL_AM_LO];
  // Unused codes above the five modes act as no detection
  wire am_active = (rx_addr_mode_field < `UAIST_AM_OFF);

  // ***************************************************
  // Receive queue
  // ***************************************************
  wire [7:0] q_head;
  wire q_empty;
  wire q_full;

  uaist_rx_queue #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .push(rx_char_valid),
    .push_data(rx_char_data),
    .pop(rd_rxd),
    .flush(rx_clear),
    .head_data(q_head),
    .empty(q_empty),
    .full(q_full)
  );

  // ***************************************************
  // Address compare
  // ***************************************************
  // Second address dropped in half duplex to save a comparator
  wire cmp1 = (rx_char_data == addr1_r);
  wire cmp2 = (HALF_DUPLEX == 0) && (rx_char_data == addr2_r);
  wire addr_hit = (ADDR_DETECT != 0) && am_active && rx_char_ninth && (cmp1 || cmp2);

  // ***************************************************
  // Receive status flags
  // ***************************************************
  // Bit 0 is live queue state, bit 6 is rewritten by each new character, bits 7:1 all clear on status read, the rest sticky until then
  reg [7:1] rx_sticky_r;
  reg [7:1] rx_set;
  reg [7:1] rx_sticky_nxt;

  always @*
  begin
    rx_set = 7'h00;
    rx_set[`UAIST_RXS_PAR] = rx_char_valid && rx_char_parity_bad;
    rx_set[`UAIST_RXS_FRAME] = rx_char_valid && rx_char_stop_low;
    rx_set[`UAIST_RXS_BREAK] = rx_break_detect;
    rx_set[`UAIST_RXS_OVR] = rx_char_valid && q_full && !rd_rxd;
    rx_set[`UAIST_RXS_HIT] = rx_char_valid && addr_hit;
    rx_set[`UAIST_RXS_NINTH] = (ADDR_DETECT != 0) && rx_char_valid && rx_char_ninth;
    rx_set[`UAIST_RXS_RING] = rx_ring_overflow;
    rx_sticky_nxt = rx_sticky_r | rx_set;
    if (rx_char_valid && (ADDR_DETECT != 0))
      rx_sticky_nxt[`UAIST_RXS_NINTH] = rx_char_ninth;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_sticky_r <= 7'h00;
    else if (rd_rxs)
      rx_sticky_r <= rx_set;
    else
      rx_sticky_r <= rx_sticky_nxt;
  end

  // Ninth bit is rewritten with each new character so it tracks the latest one
  wire [7:0] rx_status = {rx_sticky_r, !q_empty};

  // ***************************************************
  // Transmit status flags
  // ***************************************************
  reg [3:0] tx_sticky_r;
  wire [3:0] tx_set = {!tx_queue_full, tx_queue_full, tx_queue_empty, tx_byte_done};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_sticky_r <= 4'h0;
    else if (rd_txs)
      tx_sticky_r <= tx_set;
    else
      tx_sticky_r <= tx_sticky_r | tx_set;
  end

  // ***************************************************
  // Interrupts
  // ***************************************************
  wire rx_ie = (RX_INT_PRESENT != 0) && ctrl_r[`UAIST_CTL_RXIE];
  assign rx_irq = rx_ie && |(rx_status & rx_mask_r);
  assign tx_irq = ctrl_r[`UAIST_CTL_TXIE] && |(tx_sticky_r & tx_mask_r);

  // ***************************************************
  // Read data
  // ***************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        // Folds in this edge's events, which the access edge would clear unseen
        `UAIST_RX_STATUS_OFS: prdata <= {24'h000000, rx_sticky_nxt, !q_empty || rx_char_valid};
        `UAIST_RX_DATA_OFS: prdata <= {24'h000000, (q_empty && rx_char_valid) ? rx_char_data : q_head};
        `UAIST_RX_MASK_OFS: prdata <= {24'h000000, rx_mask_r};
        `UAIST_TX_STATUS_OFS: prdata <= {28'h0000000, tx_sticky_r | tx_set};
        `UAIST_TX_MASK_OFS: prdata <= {28'h0000000, tx_mask_r};
        `UAIST_CTRL_OFS: prdata <= {24'h000000, ctrl_r};
        `UAIST_ADDR1_OFS: prdata <= {24'h000000, addr1_r};
        `UAIST_ADDR2_OFS: prdata <= {24'h000000, addr2_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // uaist_top

// ===== inc/uaist_regs.vh
// Register map, field positions and reset values of the status and interrupt block.
// Assumes an APB slave with 32-bit data; each register one aligned word.
// Overview of operation
// - Receive mask enables each receive status flag
// - Byte-available set while receive queue non-empty
// - Parity mismatch sets parity error flag
// - Low stop bit sets framing error flag
// - Detected line break sets break flag
// - Byte arriving into full queue sets overrun unless a data read pops in the same cycle
// - Address byte matching either address sets hit
// - Half duplex compares first address only
// - Ninth bit flag reports parity position value
// - Status read clears all but byte-available
// - Byte-available drops when data read empties queue
// - Data read returns byte, advances queue
// - Address mode selects one of five modes
// - Transmit mask enables four transmit sources
// - Separate transmit enable gates transmit interrupt
// - Receive interrupt has own enable, optional
// - Receive clear empties the receive queue
// - Address mode held in three-bit field
// - Direction bit low receive, high transmit
// - Transmit status read clears its flags
`ifndef UAIST_REGS_VH
`define UAIST_REGS_VH

// ***************************************************
// Offsets
// ***************************************************
`define UAIST_RX_STATUS_OFS 12'h000
`define UAIST_RX_DATA_OFS 12'h004
`define UAIST_RX_MASK_OFS 12'h008
`define UAIST_TX_STATUS_OFS 12'h00C
`define UAIST_TX_MASK_OFS 12'h010
`define UAIST_CTRL_OFS 12'h014
`define UAIST_ADDR1_OFS 12'h018
`define UAIST_ADDR2_OFS 12'h01C
`define UAIST_CMD_OFS 12'h020

// ***************************************************
// Receive status bits
// ***************************************************
`define UAIST_RXS_AVAIL 0
`define UAIST_RXS_PAR 1
`define UAIST_RXS_FRAME 2
`define UAIST_RXS_BREAK 3
`define UAIST_RXS_OVR 4
`define UAIST_RXS_HIT 5
`define UAIST_RXS_NINTH 6
`define UAIST_RXS_RING 7

// ***************************************************
// Transmit status bits
// ***************************************************
`define UAIST_TXS_DONE 0
`define UAIST_TXS_EMPTY 1
`define UAIST_TXS_FULL 2
`define UAIST_TXS_ROOM 3

// ***************************************************
// Control fields
// ***************************************************
`define UAIST_CTL_DIR 0
`define UAIST_CTL_RXIE 1
`define UAIST_CTL_TXIE 2
`define UAIST_CTL_AM_LO 4
`define UAIST_CTL_AM_HI 6
`define UAIST_CMD_RXCLR 0

// ***************************************************
// Address modes
// ***************************************************
`define UAIST_AM_SOFT_EACH 3'h0
`define UAIST_AM_SOFT_TO_QUEUE 3'h1
`define UAIST_AM_HARD_EACH 3'h2
`define UAIST_AM_HARD_TO_QUEUE 3'h3
`define UAIST_AM_OFF 3'h4

// ***************************************************
// Reset values
// ***************************************************
`define UAIST_CTRL_RST 8'h40
`define UAIST_MASK_RST 8'h00
`define UAIST_ADDR_RST 8'h00

`endif

// ===== sim/test_uart_status_interrupt_addr_detect.sv
// Bench for the status block: APB tasks and line-side strobes.
// Assumes a zero-wait slave and a receive queue four deep.
`timescale 1ns/1ns
`include "uaist_regs.vh"
module test_uart_status_interrupt_addr_detect;
  reg pclk, presetn, psel, penable, pwrite, tx_byte_done, tx_queue_empty, tx_queue_full;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg rd_e;
  wire pready, pslverr, rx_char_valid, rx_char_parity_bad, rx_char_stop_low, rx_char_ninth;
  wire rx_break_detect, rx_ring_overflow, half_duplex_direction, rx_irq, tx_irq;
  wire [31:0] prdata;
  wire [7:0] rx_char_data;
  wire [2:0] rx_addr_mode_field;
  integer bad_count, comparisons, i;
  uaist_top uaist_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .rx_char_valid, .rx_char_data, .rx_char_parity_bad, .rx_char_stop_low,
    .rx_char_ninth, .rx_break_detect, .rx_ring_overflow, .tx_byte_done, .tx_queue_empty,
    .tx_queue_full, .half_duplex_direction, .rx_addr_mode_field, .rx_irq, .tx_irq);
  uaist_rx_node uaist_rx_node_i (.pclk, .rx_char_valid, .rx_char_data, .rx_char_parity_bad,
    .rx_char_stop_low, .rx_char_ninth, .rx_break_detect, .rx_ring_overflow);
  // ****
  // Tasks
  // ****
  task give_verdict;
  begin
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input [8*8-1:0] n, input [31:0] e, input [31:0] s);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0s expected %h seen %h", n, e, s);
    end
  end
  endtask
  // Reads compare prdata at the pready edge
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_e = pslverr;
    if (!w)
      chk("prdata", d, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #500000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, tx_byte_done, tx_queue_empty, tx_queue_full} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, `UAIST_CTRL_OFS, 32'h40);
    xfer(0, `UAIST_RX_MASK_OFS, 32'h0);
    for (i = 0; i < 5; i = i + 1)
    begin
      xfer(1, `UAIST_CTRL_OFS, {25'h0, i[2:0], 3'h0, i[0]});
      chk("mode", i, {29'h0, rx_addr_mode_field});
      chk("dir", i & 1, {31'h0, half_duplex_direction});
    end
    uaist_rx_node_i.send(8'h11, 4'h0);
    uaist_rx_node_i.send(8'h22, 4'h0);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h01);
    xfer(0, `UAIST_RX_DATA_OFS, 32'h11);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h01);
    xfer(0, `UAIST_RX_DATA_OFS, 32'h22);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      uaist_rx_node_i.send(8'h30, 4'h1 << i);
      xfer(0, `UAIST_RX_STATUS_OFS, 32'h1 | (32'h2 << i));
      xfer(0, `UAIST_RX_STATUS_OFS, 32'h01);
      xfer(0, `UAIST_RX_DATA_OFS, 32'h30);
    end
    for (i = 0; i < 5; i = i + 1)
      uaist_rx_node_i.send(i[7:0], 4'h0);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h11);
    xfer(1, `UAIST_CMD_OFS, 32'h1);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h00);
    uaist_rx_node_i.ring_overflow;
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h80);
    xfer(1, `UAIST_ADDR1_OFS, 32'h5A);
    xfer(1, `UAIST_ADDR2_OFS, 32'hA5);
    uaist_rx_node_i.send(8'h5A, 4'h8);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h41);
    xfer(0, `UAIST_RX_DATA_OFS, 32'h5A);
    xfer(1, `UAIST_CTRL_OFS, 32'h20);
    uaist_rx_node_i.send(8'hA5, 4'h8);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h61);
    uaist_rx_node_i.send(8'h5A, 4'h8);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h61);
    uaist_rx_node_i.send(8'h33, 4'h8);
    uaist_rx_node_i.send(8'h44, 4'h0);
    xfer(0, `UAIST_RX_STATUS_OFS, 32'h01);
    xfer(1, `UAIST_RX_MASK_OFS, 32'h01);
    chk("rx_irq", 0, {31'h0, rx_irq});
    xfer(1, `UAIST_CTRL_OFS, 32'h22);
    chk("rx_irq", 1, {31'h0, rx_irq});
    xfer(1, `UAIST_RX_MASK_OFS, 32'h00);
    chk("rx_irq", 0, {31'h0, rx_irq});
    @(posedge pclk);
    tx_queue_empty <= 1'b1;
    xfer(1, `UAIST_TX_MASK_OFS, 32'h02);
    chk("tx_irq", 0, {31'h0, tx_irq});
    xfer(1, `UAIST_CTRL_OFS, 32'h24);
    chk("tx_irq", 1, {31'h0, tx_irq});
    @(posedge pclk);
    tx_byte_done <= 1'b1;
    @(posedge pclk);
    tx_byte_done <= 1'b0;
    xfer(0, `UAIST_TX_STATUS_OFS, 32'h0B);
    xfer(0, `UAIST_TX_STATUS_OFS, 32'h0A);
    @(posedge pclk);
    {tx_queue_empty, tx_queue_full} <= 2'b01;
    xfer(0, `UAIST_TX_STATUS_OFS, 32'h0E);
    xfer(0, `UAIST_TX_STATUS_OFS, 32'h04);
    xfer(0, 12'h0FC, 32'h0);
    chk("pslverr", 1, {31'h0, rd_e});
    give_verdict;
  end
endmodule // test_uart_status_interrupt_addr_detect

// ===== sim/uaist_chk_sva.sv
// Port checker for the status block.
// Assumes the bench leaves an idle cycle between APB transfers.
`timescale 1ns/1ns
module uaist_chk (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Receiver core
  input wire rx_char_valid,
  input wire rx_char_parity_bad,
  input wire rx_char_stop_low,
  input wire rx_break_detect,
  input wire rx_ring_overflow,
  // Controls
  input wire half_duplex_direction,
  input wire [2:0] rx_addr_mode_field,
  input wire rx_irq,
  input wire tx_irq
);
  // ****
  // Shadow of the interrupt enables
  // ****
  reg rxie_r;
  reg txie_r;
  wire ctl_wr = psel && penable && pwrite && paddr == 12'h014;
  wire st_set = psel && !penable && !pwrite && paddr == 12'h000;
  wire st_acc = psel && penable && !pwrite && paddr == 12'h000;
  // No event may land in the clear window
  wire quiet = !rx_char_valid && !rx_break_detect && !rx_ring_overflow;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rxie_r <= 1'b0;
      txie_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      rxie_r <= pwdata[1];
      txie_r <= pwdata[2];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_avail; rx_char_valid ##2 st_set |=> prdata[0]; endproperty
  property p_par; rx_char_valid && rx_char_parity_bad ##2 st_set |=> prdata[1]; endproperty
  property p_frm; rx_char_valid && rx_char_stop_low ##2 st_set |=> prdata[2]; endproperty
  property p_brk; rx_break_detect ##2 st_set |=> prdata[3]; endproperty
  property p_clr; st_acc && quiet ##1 quiet ##1 st_set && quiet |=> prdata[7:1] == 7'h00; endproperty
  property p_dir; ctl_wr |=> half_duplex_direction == $past(pwdata[0]); endproperty
  property p_mode; ctl_wr |=> rx_addr_mode_field == $past(pwdata[6:4]); endproperty
  property p_txg; !txie_r |-> !tx_irq; endproperty
  property p_rxg; !rxie_r |-> !rx_irq; endproperty
  a_avail: assert property (p_avail) else $error("avail flag missing");
  a_par: assert property (p_par) else $error("parity flag missing");
  a_frm: assert property (p_frm) else $error("framing flag missing");
  a_brk: assert property (p_brk) else $error("break flag missing");
  a_clr: assert property (p_clr) else $error("status not cleared");
  a_dir: assert property (p_dir) else $error("direction bit wrong");
  a_mode: assert property (p_mode) else $error("mode field wrong");
  a_txg: assert property (p_txg) else $error("tx irq not gated");
  a_rxg: assert property (p_rxg) else $error("rx irq not gated");
  c_rx: cover property (rx_irq);
  c_tx: cover property (tx_irq);
  c_clr: cover property (p_clr);
endmodule // uaist_chk
bind uaist_top uaist_chk uaist_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .rx_char_valid, .rx_char_parity_bad, .rx_char_stop_low, .rx_break_detect,
  .rx_ring_overflow, .half_duplex_direction, .rx_addr_mode_field, .rx_irq, .tx_irq);

// ===== sim/uaist_rx_node.sv
// Remote serial node as seen through the receiver core strobe.
// Assumes send is called from one thread only.
`timescale 1ns/1ns
module uaist_rx_node (
  // Clock
  input wire pclk,
  // Character strobe
  output reg rx_char_valid,
  output reg [7:0] rx_char_data,
  output reg rx_char_parity_bad,
  output reg rx_char_stop_low,
  output reg rx_char_ninth,
  output reg rx_break_detect,
  output reg rx_ring_overflow
);
  initial
  begin
    rx_ring_overflow = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    {rx_char_ninth, rx_break_detect, rx_char_stop_low, rx_char_parity_bad} = 4'h0;
  end
  // Flags f: ninth, break, stop low, parity bad
  task send(input [7:0] d, input [3:0] f);
  begin
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    {rx_char_ninth, rx_break_detect, rx_char_stop_low, rx_char_parity_bad} <= f;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_break_detect <= 1'b0;
    // Idle qualifiers show garbage, never a held copy
    rx_char_data <= ~d;
    {rx_char_ninth, rx_char_stop_low, rx_char_parity_bad} <= {~f[3], ~f[1:0]};
  end
  endtask
  // Software ring overflow is reported from outside as a one-cycle pulse
  task ring_overflow;
  begin
    @(posedge pclk);
    rx_ring_overflow <= 1'b1;
    @(posedge pclk);
    rx_ring_overflow <= 1'b0;
  end
  endtask
endmodule // uaist_rx_node
